// ==== core/host_bus_mode_status_regs.vh ====
// register offsets, field positions and reset values of the host port mode and status registers
`ifndef HOST_BUS_MODE_STATUS_REGS_VH
`define HOST_BUS_MODE_STATUS_REGS_VH
`define BWS_BYTE_OFS0      7'h00
`define BWS_BYTE_OFS1      7'h01
`define BWS_WORD_OFS       6'h00
`define STAT_BYTE_OFS0     7'h04
`define STAT_BYTE_OFS1     7'h05
`define STAT_BYTE_OFS2     7'h06
`define STAT_BYTE_OFS3     7'h07
`define STAT_WORD_OFS_LO   6'h02
`define STAT_WORD_OFS_HI   6'h03
`define DATA_WIDTH_BIT     0
`define SEQ_LOCK_BIT       0
`define HOST_LOCK_BIT      1
`define SEQ_FAULT_BIT      2
`define CARD_FAULT_BIT     3
`define DATA_WIDTH_RST     1'b0
`define RDATA_RST          16'h0000
`endif

// ==== core/host_bus_mode_status_regs.v ====
// bus-width selector and controller state registers of the host port
//
// Operation
// (R01) the width selector is one bit seen at byte offsets 0x00 and 0x01 and word offset 0x0.
// (R02) the width selector resets to zero, so the port starts in byte mode.
// (R03) in byte mode all address lines are decoded and data moves only on lines 7:0.
// (R04) in word mode all sixteen data lines are used and only address lines 6:1 are decoded.
// (R05) the state register sits at bytes 04h-07h or words 02h-03h and is read-only.
// (R06) the state register carries the indications a host reads to find an interrupt source.
// (R07) bit 0 reads 1 while the configuration sequencer holds the card controller lock.
// (R08) bit 1 reads 1 while the host port holds the card controller lock.
// (R09) bit 2 reads 1 while the configuration sequencer reports an error.
// (R10) bit 3 reads 1 while the card controller reports an error.
// (R11) bits 7:1 of the width selector read zero and ignore writes.
`timescale 1ns/1ps
`include "host_bus_mode_status_regs.vh"

module host_bus_mode_status_regs #(
  parameter STATE_W = 32
) (
  input  wire               ref_clk,
  input  wire               rstn,
  input  wire               clk_en,
  input  wire [6:0]         host_addr,
  input  wire [15:0]        host_wdata,
  input  wire               host_wr,
  input  wire               host_rd,
  input  wire               sequencer_lock_flag,
  input  wire               host_lock_flag,
  input  wire               sequencer_fault_flag,
  input  wire               card_ctrl_fault_flag,
  input  wire [STATE_W-1:0] state_upper,
  output reg  [15:0]        host_rdata,
  output reg                host_rvalid,
  output reg                data_width_bit
);

  localparam DATA_W  = 16;
  localparam BYTE_W  = 8;
  localparam FLAG_N  = 4;
  localparam ADDR_W  = 7;
  localparam WADDR_W = 6;

  wire [STATE_W-1:0] controller_state_reg;
  wire [FLAG_N-1:0]  flag_vec;
  wire [WADDR_W-1:0] word_addr;
  wire [DATA_W-1:0]  state_lo;
  wire [DATA_W-1:0]  state_hi;
  wire               hit_width;
  wire               hit_wr;
  reg  [DATA_W-1:0]  width_img;
  reg  [DATA_W-1:0]  byte_img;
  reg  [DATA_W-1:0]  word_img;
  reg  [DATA_W-1:0]  rdata_nxt;
  reg                width_nxt;
  reg                rvalid_nxt;

  // true when an access lands on one of the width selector aliases
  function width_alias;
    input              mode;
    input [ADDR_W-1:0] addr;
    begin
      if (mode) begin
        width_alias = (addr[ADDR_W-1:1] == `BWS_WORD_OFS); // R04
      end else begin
        width_alias = (addr == `BWS_BYTE_OFS0) || (addr == `BWS_BYTE_OFS1); // R03
      end
    end
  endfunction

  // one byte lane of the controller state image
  function [BYTE_W-1:0] state_byte;
    input [STATE_W-1:0] img;
    input [1:0]         sel;
    begin
      case (sel)
        2'h0: begin
          state_byte = img[7:0];
        end
        2'h1: begin
          state_byte = img[15:8];
        end
        2'h2: begin
          state_byte = img[23:16];
        end
        default: begin
          state_byte = img[31:24];
        end
      endcase
    end
  endfunction

  // word mode drops address line 0
  assign word_addr = host_addr[ADDR_W-1:1]; // R04

  // one physical bit answers at all three aliases
  assign hit_width = width_alias(data_width_bit, host_addr); // R01 R03

  // status registers ignore writes, only the selector takes one
  assign hit_wr = host_wr & hit_width; // R05

  // live flags of the card controller lock and fault sources
  assign flag_vec[`SEQ_LOCK_BIT]   = sequencer_lock_flag;  // R07 R06
  assign flag_vec[`HOST_LOCK_BIT]  = host_lock_flag;       // R08
  assign flag_vec[`SEQ_FAULT_BIT]  = sequencer_fault_flag; // R09
  assign flag_vec[`CARD_FAULT_BIT] = card_ctrl_fault_flag; // R10

  // live status image; upper bits come from the rest of the controller
  genvar gi;
  generate
    for (gi = 0; gi < STATE_W; gi = gi + 1) begin : g_state
      if (gi < FLAG_N) begin : g_flag
        assign controller_state_reg[gi] = flag_vec[gi];
      end else begin : g_upper
        assign controller_state_reg[gi] = state_upper[gi];
      end
    end
  endgenerate

  // the two word halves of the status image
  assign state_lo = {state_byte(controller_state_reg, 2'h1),
                     state_byte(controller_state_reg, 2'h0)};
  assign state_hi = {state_byte(controller_state_reg, 2'h3),
                     state_byte(controller_state_reg, 2'h2)};

  // selector read image: reserved bits stay zero
  always @* begin
    width_img                  = `RDATA_RST;
    width_img[`DATA_WIDTH_BIT] = data_width_bit; // R11
  end

  // byte mode: one status byte on lines 7:0, upper lines zero
  always @* begin
    byte_img = `RDATA_RST;
    case (host_addr)
      `STAT_BYTE_OFS0: begin
        byte_img[BYTE_W-1:0] = state_byte(controller_state_reg, 2'h0); // R05 R03
      end
      `STAT_BYTE_OFS1: begin
        byte_img[BYTE_W-1:0] = state_byte(controller_state_reg, 2'h1); // R05
      end
      `STAT_BYTE_OFS2: begin
        byte_img[BYTE_W-1:0] = state_byte(controller_state_reg, 2'h2); // R05
      end
      `STAT_BYTE_OFS3: begin
        byte_img[BYTE_W-1:0] = state_byte(controller_state_reg, 2'h3); // R05
      end
      default: begin
        byte_img = `RDATA_RST;
      end
    endcase
  end

  // word mode: a status half on all sixteen lines
  always @* begin
    word_img = `RDATA_RST;
    case (word_addr)
      `STAT_WORD_OFS_LO: begin
        word_img = state_lo; // R05 R04
      end
      `STAT_WORD_OFS_HI: begin
        word_img = state_hi; // R05
      end
      default: begin
        word_img = `RDATA_RST;
      end
    endcase
  end

  // decoding follows the width in force at the edge of the access
  always @* begin
    if (hit_width) begin
      rdata_nxt = width_img;
    end else if (data_width_bit) begin
      rdata_nxt = word_img; // R04
    end else begin
      rdata_nxt = byte_img; // R03
    end
  end

  // selector next value: only an aliased write moves it
  always @* begin
    width_nxt = data_width_bit;
    if (hit_wr) begin
      width_nxt = host_wdata[`DATA_WIDTH_BIT]; // R01 R11
    end
  end

  // read answer strobe follows the read strobe by one cycle
  always @* begin
    rvalid_nxt = host_rd;
  end

  // selector flop: reset puts the port in byte mode
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      data_width_bit <= `DATA_WIDTH_RST; // R02
    end else if (clk_en) begin
      data_width_bit <= width_nxt;
    end
  end

  // answer strobe flop, frozen with the clock enable
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      host_rvalid <= 1'h0;
    end else if (clk_en) begin
      host_rvalid <= rvalid_nxt;
    end
  end

  // read data holds until the next read
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      host_rdata <= `RDATA_RST;
    end else if (clk_en) begin
      if (host_rd) begin
        host_rdata <= rdata_nxt;
      end
    end
  end

endmodule // host_bus_mode_status_regs

// ==== tb/port_chk_assertions.sv ====
// checker for the host port registers
`timescale 1ns/1ps
module port_chk #(parameter STATE_W=32) (input ref_clk, rstn, clk_en, host_wr, host_rd,
  host_rvalid, data_width_bit, sequencer_lock_flag, host_lock_flag, sequencer_fault_flag,
  card_ctrl_fault_flag, input [6:0] host_addr, input [15:0] host_wdata, host_rdata,
  input [STATE_W-1:0] state_upper);
  wire [31:0] s={state_upper[31:4], card_ctrl_fault_flag, sequencer_fault_flag,
    host_lock_flag, sequencer_lock_flag};
  wire [5:0] a=host_addr[6:1];
  wire r=clk_en&host_rd, m=data_width_bit, w=clk_en&host_wr&a==0, b=r&!m;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  rd_ans_a: assert property (r|=>host_rvalid) else $error("rvalid");
  width_wr_a: assert property (w|=>m==$past(host_wdata[0])) else $error("wr");
  width_keep_a: assert property (!w|=>$stable(m)) else $error("keep");
  width_rd_a: assert property (r&a==0|=>host_rdata==$past(m)) else $error("rd");
  byte_hi_a: assert property (b|=>host_rdata[15:8]==0) else $error("hi");
  byte_lo_a: assert property (b&host_addr==4|=>host_rdata[7:0]==$past(s[7:0])) else $error("b");
  word_lo_a: assert property (r&m&a==2|=>host_rdata==$past(s[15:0])) else $error("lo");
  word_hi_a: assert property (r&m&a==3|=>host_rdata==$past(s[31:16])) else $error("wh");
  cover property (r&m); cover property (w&host_wdata[0]); cover property (b&a==0);
endmodule // port_chk
bind host_bus_mode_status_regs port_chk #(.STATE_W(STATE_W)) port_chk_i (.ref_clk(ref_clk),
  .rstn(rstn), .clk_en(clk_en), .host_wr(host_wr), .host_rd(host_rd),
  .host_rvalid(host_rvalid), .data_width_bit(data_width_bit),
  .sequencer_lock_flag(sequencer_lock_flag), .host_lock_flag(host_lock_flag),
  .sequencer_fault_flag(sequencer_fault_flag), .card_ctrl_fault_flag(card_ctrl_fault_flag),
  .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
  .state_upper(state_upper));

// ==== tb/host_model.sv ====
// host processor model: one-cycle strobes, idle lines inverted
`timescale 1ns/1ps
module host_model (input ref_clk, host_rvalid, input [15:0] host_rdata, output reg host_wr=0,
  output reg host_rd=0, output reg [6:0] host_addr=0, output reg [15:0] host_wdata=0);
  task acc(input w, input [6:0] a, input [15:0] d, output [15:0] q, output ok);
    @(posedge ref_clk) #1 {host_wr, host_rd, host_addr, host_wdata}={w, !w, a, d};
    @(posedge ref_clk) #1 {host_wr, host_rd, host_addr, host_wdata}={2'b0, ~a, ~d};
    {q, ok}={host_rdata, host_rvalid|w};
  endtask
endmodule // host_model

// ==== tb/tb.sv ====
// bench for the host port registers
`timescale 1ns/1ps
module tb;
  reg ref_clk=0, rstn=0, sequencer_lock_flag=0, host_lock_flag=0, sequencer_fault_flag=0;
  reg card_ctrl_fault_flag=0, ok, clk_en=1;
  reg [31:0] state_upper=32'ha5c396f0;
  reg [15:0] q;
  wire [6:0] host_addr;
  wire [15:0] host_wdata, host_rdata;
  wire host_wr, host_rd, host_rvalid, data_width_bit;
  integer n_mismatch=0, n_tests=0, k;
  always #2.5 ref_clk=~ref_clk;
  host_bus_mode_status_regs host_bus_mode_status_regs_i (.*);
  host_model host_model_i (.*);
  task rw(input w, input [6:0] a, input [15:0] d);
    host_model_i.acc(w, a, d, q, ok);
    n_tests++;
    if (ok!==1 || !w && q!==d) begin n_mismatch++; $display("CHECK FAILED %0t got %h", $time, q); end
  endtask
  task chk_mode(input e);
    n_tests++;
    if (data_width_bit!==e) begin n_mismatch++; $display("CHECK FAILED %0t mode", $time); end
  endtask
  task end_sim;
    if (n_mismatch==0 && n_tests>0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    #1 rstn=1;
    rw(0, 7'h01, 16'h0000);
    for (k=0; k<16; k++) begin
      {card_ctrl_fault_flag, sequencer_fault_flag, host_lock_flag, sequencer_lock_flag}=k[3:0];
      rw(0, 7'h04, {state_upper[7:4], k[3:0]});
    end
    rw(1, 7'h04, 16'hffff);
    rw(0, 7'h07, state_upper[31:24]);
    rw(1, 7'h01, 16'h00ff);
    chk_mode(1);
    rw(0, 7'h00, 16'h0001);
    rw(0, 7'h05, {state_upper[15:4], 4'hf});
    rw(0, 7'h06, state_upper[31:16]);
    clk_en=0;
    rw(1, 7'h00, 16'h0000);
    clk_en=1;
    rw(0, 7'h00, 16'h0001);
    rw(1, 7'h01, 16'h0000);
    rw(0, 7'h00, 16'h0000);
    rw(1, 7'h00, 16'h0001);
    rstn=0;
    repeat (2) @(posedge ref_clk);
    #1 rstn=1;
    chk_mode(0);
    rw(0, 7'h01, 16'h0000);
    end_sim;
  end
endmodule // tb
